// ==== ca_vref_pkg.sv ====
// Constants and types shared by the command/address reference register
package ca_vref_pkg;
	// Mode register address and field layout
	localparam logic [5:0] CA_REF_ADDR = 6'h0C;
	localparam int LEVEL_LSB = 0;
	localparam int LEVEL_MSB = 5;
	localparam int RANGE_BIT = 6;
	localparam int CBT_BIT = 7;
	localparam logic [5:0] LEVEL_MAX_CODE = 6'h32;
	localparam int NUM_SETPOINTS = 2;
	// Reset values
	localparam logic [5:0] LEVEL_RST = 6'h0D;
	localparam logic RANGE_RST = 1'h1;
	localparam logic CBT_RST = 1'h0;
	localparam logic [7:0] COPY_RST = {CBT_RST, RANGE_RST, LEVEL_RST};
	localparam logic [7:0] DQ_IDLE = 8'h00;
	// Reference level in tenths of a percent of the I/O supply
	localparam logic [9:0] RANGE0_BASE = 10'h096;
	localparam logic [9:0] RANGE1_BASE = 10'h149;
	localparam logic [15:0] RANGE0_SPAN = 16'h012B;
	localparam logic [15:0] RANGE1_SPAN = 16'h012C;
	localparam logic [15:0] SPAN_STEPS = 16'h0032;

	typedef struct packed {
		logic [7:0] value;
	} copy_state_t;
endpackage : ca_vref_pkg

// ==== setpoint_if.sv ====
// Carrier between the register front end and the set point copies
`timescale 1ns/1ps
interface setpoint_if;
	logic [1:0] wr_en;
	logic [7:0] wr_data;
	logic [7:0] value [2];

	modport ctrl (output wr_en, output wr_data, input value);
	modport store (input wr_en, input wr_data, output value);
endinterface : setpoint_if

// ==== setpoint_copy.sv ====
// One physical copy of the register for a single set point
`timescale 1ns/1ps
module setpoint_copy #(
	parameter int IDX = 0
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	setpoint_if.store sp
);
	ca_vref_pkg::copy_state_t state_ff;
	ca_vref_pkg::copy_state_t nxt_state;

	// Refuse an index with no copy behind it
	if (IDX < 0 || IDX >= ca_vref_pkg::NUM_SETPOINTS)
	begin : g_bad_idx
		$error("setpoint_copy: IDX out of range");
	end

	always_comb
	begin
		nxt_state = state_ff;
		if (sp.wr_en[IDX])
			nxt_state.value = sp.wr_data;
	end

	// Held until overwritten or reset
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			state_ff <= '{value: ca_vref_pkg::COPY_RST};
		else if (clk_en_in)
			state_ff <= nxt_state;
	end

	assign sp.value[IDX] = state_ff.value;
endmodule : setpoint_copy

// ==== ca_vref_mode_register.sv ====
// Command/address reference mode register with two set point copies
`timescale 1ns/1ps
// What this block does
// - Level code 0 to 50 valid; other codes reserved, writes carrying them dropped.
// - Bit 6 picks reference range; range 1 after reset.
// - Bit 7 picks training byte mode 1 or 2; mode 2 only on x8.
// - Read drives all eight bits on data lines; idle lines are zero.
// - Write lands in the copy chosen by write-select.
// - Two copies per bit; reads return the write-selected copy.
// - Device runs from operate-selected copy; the other may change freely.
// - Contents kept until rewritten or reset.
// - Code maps to supply fraction: range 0 15.0-44.9, range 1 32.9-62.9.
// - Write-select is a plain input with no reset here; the bench starts it at 0.
module ca_vref_mode_register (
	// Clock, reset, enable
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// Mode register commands
	input wire logic mode_register_write_in,
	input wire logic mode_register_read_in,
	input wire logic [5:0] mode_addr_in,
	input wire logic [7:0] op_in,
	// Set point selects and device width
	input wire logic setpoint_write_select_in,
	input wire logic setpoint_operate_select_in,
	input wire logic byte_mode_in,
	// Read data
	output logic [7:0] dq_out,
	output logic dq_valid_out,
	// Active operating values
	output logic [5:0] ca_reference_level_out,
	output logic ca_reference_range_select_out,
	output logic cmd_bus_training_byte_select_out,
	output logic [9:0] ca_reference_tenths_out
);
	typedef struct packed {
		logic [7:0] dq;
		logic dq_valid;
		logic [5:0] level;
		logic range_sel;
		logic cbt;
		logic [9:0] tenths;
	} top_state_t;

	top_state_t state_ff;
	top_state_t nxt_state;
	setpoint_if sp ();

	logic hit;
	logic code_ok;
	logic [7:0] wr_copy;
	logic [7:0] rd_copy;
	logic [7:0] act_copy;
	logic [15:0] scaled;

	// ------------------------------------------------------------
	// Set point copies
	// ------------------------------------------------------------
	for (genvar i = 0; i < ca_vref_pkg::NUM_SETPOINTS; i++)
	begin : g_copy
		setpoint_copy #(.IDX(i)) u_copy (
			.ref_clk_in(ref_clk_in),
			.sys_rst_in(sys_rst_in),
			.clk_en_in(clk_en_in),
			.sp(sp.store)
		);
	end

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	assign hit = (mode_addr_in == ca_vref_pkg::CA_REF_ADDR);
	// Reserved codes are dropped whole
	assign code_ok =
		(op_in[ca_vref_pkg::LEVEL_MSB:ca_vref_pkg::LEVEL_LSB]
		<= ca_vref_pkg::LEVEL_MAX_CODE);

	always_comb
	begin
		wr_copy = op_in;
		if (!byte_mode_in)
			wr_copy[ca_vref_pkg::CBT_BIT] = 1'b0;
	end

	assign sp.wr_data = wr_copy;
	assign sp.wr_en[0] = mode_register_write_in && hit && code_ok
		&& !setpoint_write_select_in;
	assign sp.wr_en[1] = mode_register_write_in && hit && code_ok
		&& setpoint_write_select_in;

	assign rd_copy = setpoint_write_select_in ? sp.value[1]
		: sp.value[0];
	assign act_copy = setpoint_operate_select_in ? sp.value[1]
		: sp.value[0];

	// ------------------------------------------------------------
	// Level scaling
	// ------------------------------------------------------------
	always_comb
	begin
		scaled = 16'(act_copy[ca_vref_pkg::LEVEL_MSB:ca_vref_pkg::LEVEL_LSB])
			* (act_copy[ca_vref_pkg::RANGE_BIT] ? ca_vref_pkg::RANGE1_SPAN
			: ca_vref_pkg::RANGE0_SPAN);
		scaled = scaled / ca_vref_pkg::SPAN_STEPS;
	end

	// ------------------------------------------------------------
	// State update
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.dq_valid = 1'b0;
		nxt_state.dq = ca_vref_pkg::DQ_IDLE;
		if (mode_register_read_in && hit)
		begin
			nxt_state.dq_valid = 1'b1;
			nxt_state.dq = rd_copy;
		end
		nxt_state.level =
			act_copy[ca_vref_pkg::LEVEL_MSB:ca_vref_pkg::LEVEL_LSB];
		nxt_state.range_sel = act_copy[ca_vref_pkg::RANGE_BIT];
		nxt_state.cbt = act_copy[ca_vref_pkg::CBT_BIT];
		nxt_state.tenths = (act_copy[ca_vref_pkg::RANGE_BIT]
			? ca_vref_pkg::RANGE1_BASE : ca_vref_pkg::RANGE0_BASE)
			+ scaled[9:0];
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			state_ff.dq <= ca_vref_pkg::DQ_IDLE;
			state_ff.dq_valid <= 1'h0;
			state_ff.level <= ca_vref_pkg::LEVEL_RST;
			state_ff.range_sel <= ca_vref_pkg::RANGE_RST;
			state_ff.cbt <= ca_vref_pkg::CBT_RST;
			// Level matches the reset code, not the bare range base
			state_ff.tenths <= ca_vref_pkg::RANGE1_BASE
				+ 10'(16'(ca_vref_pkg::LEVEL_RST)
				* ca_vref_pkg::RANGE1_SPAN
				/ ca_vref_pkg::SPAN_STEPS);
		end
		else if (clk_en_in)
			state_ff <= nxt_state;
	end

	assign dq_out = state_ff.dq;
	assign dq_valid_out = state_ff.dq_valid;
	assign ca_reference_level_out = state_ff.level;
	assign ca_reference_range_select_out = state_ff.range_sel;
	assign cmd_bus_training_byte_select_out = state_ff.cbt;
	assign ca_reference_tenths_out = state_ff.tenths;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_write_sp_zero: assert property (
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && mode_register_write_in && hit && code_ok
		&& !setpoint_write_select_in |=> sp.value[0] == $past(wr_copy))
		else $error("set point 0 write lost");

	a_write_sp_one: assert property (
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && mode_register_write_in && hit && code_ok
		&& setpoint_write_select_in |=> sp.value[1] == $past(wr_copy))
		else $error("set point 1 write lost");

	a_other_copy_kept: assert property (
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && mode_register_write_in && !setpoint_write_select_in
		|=> $stable(sp.value[1]))
		else $error("unselected copy changed");

	a_reserved_dropped: assert property (
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && !code_ok |=> $stable(sp.value[0])
		&& $stable(sp.value[1]))
		else $error("reserved code stored");

	a_read_returns: assert property (
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && mode_register_read_in && hit
		|=> dq_valid_out && dq_out == $past(rd_copy))
		else $error("read data wrong");

	a_dq_idle_zero: assert property (
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		!dq_valid_out |-> dq_out == ca_vref_pkg::DQ_IDLE)
		else $error("idle data lines not zero");

	a_active_follows: assert property (
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in |=> {cmd_bus_training_byte_select_out,
		ca_reference_range_select_out, ca_reference_level_out}
		== $past(act_copy))
		else $error("operating value not from active copy");

	a_reset_range: assert property (
		@(posedge ref_clk_in)
		sys_rst_in |=> sp.value[0][ca_vref_pkg::RANGE_BIT]
		&& sp.value[1][ca_vref_pkg::RANGE_BIT])
		else $error("range not 1 after reset");

	a_cbt_byte_only: assert property (
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && mode_register_write_in && !byte_mode_in
		&& !setpoint_write_select_in |=> !sp.value[0][ca_vref_pkg::CBT_BIT])
		else $error("byte mode 2 taken on wide device");

	a_frozen_hold: assert property (
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		!clk_en_in |=> $stable(sp.value[0]) && $stable(sp.value[1])
		&& $stable(dq_out))
		else $error("state moved while frozen");

	a_foreign_ignored: assert property (
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && !hit
		&& (mode_register_write_in || mode_register_read_in)
		|=> $stable(sp.value[0]) && $stable(sp.value[1])
		&& !dq_valid_out)
		else $error("command to other address acted on");

	a_reset_outputs: assert property (
		@(posedge ref_clk_in)
		sys_rst_in |=> ca_reference_range_select_out && !dq_valid_out
		&& ca_reference_level_out == ca_vref_pkg::LEVEL_RST)
		else $error("outputs not at reset values");
endmodule : ca_vref_mode_register

// ==== mode_cmd_master.sv ====
// Controller model that issues mode register commands
`timescale 1ns/1ps
module mode_cmd_master (
	// Clock
	input wire logic ref_clk_in,
	// Command lines
	output logic wr_out,
	output logic rd_out,
	output logic [5:0] addr_out,
	output logic [7:0] op_out
);
	initial
	begin
		wr_out = 1'h0;
		rd_out = 1'h0;
		addr_out = 6'h00;
		op_out = 8'h00;
	end

	// Held for one take edge; on release strobes drop, address and data get inverted garbage
	task automatic issue(input logic w, input logic [5:0] a,
		input logic [7:0] d);
		@(posedge ref_clk_in);
		#2;
		wr_out = w;
		rd_out = !w;
		addr_out = a;
		op_out = d;
		@(posedge ref_clk_in);
		#2;
		wr_out = 1'h0;
		rd_out = 1'h0;
		addr_out = ~a;
		op_out = ~d;
	endtask : issue
endmodule : mode_cmd_master

// ==== test_ca_vref_mode_register.sv ====
// Self-checking bench for the reference mode register
`timescale 1ns/1ps
module test_ca_vref_mode_register;
	logic ref_clk_in = 1'h0;
	logic sys_rst_in = 1'h1;
	logic clk_en = 1'h1;
	logic wsel = 1'h0;
	logic osel = 1'h0;
	logic bmode = 1'h0;
	logic wr, rd, dq_valid, range_sel, cbt;
	logic [5:0] addr, level;
	logic [7:0] op, dq;
	logic [9:0] tenths;
	logic [7:0] copy_exp [2];
	logic [7:0] v;
	int fails = 0;
	int samples_checked = 0;
	int seed = 5894;

	always #12.5 ref_clk_in = ~ref_clk_in;

	mode_cmd_master i_mode_cmd_master (.ref_clk_in(ref_clk_in),
		.wr_out(wr), .rd_out(rd), .addr_out(addr), .op_out(op));

	ca_vref_mode_register i_ca_vref_mode_register (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en), .mode_register_write_in(wr),
		.mode_register_read_in(rd), .mode_addr_in(addr), .op_in(op),
		.setpoint_write_select_in(wsel),
		.setpoint_operate_select_in(osel), .byte_mode_in(bmode),
		.dq_out(dq), .dq_valid_out(dq_valid),
		.ca_reference_level_out(level),
		.ca_reference_range_select_out(range_sel),
		.cmd_bus_training_byte_select_out(cbt),
		.ca_reference_tenths_out(tenths));

	function automatic logic [9:0] exp_tenths(input logic [7:0] c);
		logic [15:0] s;
		s = c[6] ? ca_vref_pkg::RANGE1_SPAN : ca_vref_pkg::RANGE0_SPAN;
		s = 16'(c[5:0]) * s / ca_vref_pkg::SPAN_STEPS;
		return (c[6] ? ca_vref_pkg::RANGE1_BASE
			: ca_vref_pkg::RANGE0_BASE) + s[9:0];
	endfunction : exp_tenths

	task automatic chk(input logic [9:0] got, input logic [9:0] exp,
		input string m);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : chk

	task automatic wr_op(input logic [5:0] a, input logic [7:0] d);
		i_mode_cmd_master.issue(1'h1, a, d);
		if (a == ca_vref_pkg::CA_REF_ADDR &&
			d[5:0] <= ca_vref_pkg::LEVEL_MAX_CODE)
			copy_exp[wsel] = {d[7] & bmode, d[6:0]};
	endtask : wr_op

	task automatic rd_act;
		i_mode_cmd_master.issue(1'h0, ca_vref_pkg::CA_REF_ADDR, 8'h00);
		chk(10'(dq_valid), 10'h001, "read valid");
		chk(10'(dq), 10'(copy_exp[wsel]), "read data");
		@(posedge ref_clk_in);
		#2;
		chk(10'(dq), 10'h000, "idle dq");
		v = copy_exp[osel];
		chk(10'(level), 10'(v[5:0]), "level");
		chk(10'(range_sel), 10'(v[6]), "range");
		chk(10'(cbt), 10'(v[7]), "cbt");
		chk(tenths, exp_tenths(v), "tenths");
	endtask : rd_act

	task automatic print_verdict;
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	initial
	begin
		#(25 * 5000);
		fails++;
		print_verdict();
	end

	initial
	begin
		copy_exp = '{ca_vref_pkg::COPY_RST, ca_vref_pkg::COPY_RST};
		repeat (10) @(posedge ref_clk_in);
		#2;
		sys_rst_in = 1'h0;
		rd_act();
		wr_op(ca_vref_pkg::CA_REF_ADDR, 8'hB2);
		rd_act();
		chk(tenths, 10'h1C1, "range 0 top");
		wr_op(ca_vref_pkg::CA_REF_ADDR, 8'h33);
		wr_op(6'h0D, 8'h05);
		rd_act();
		wr_op(ca_vref_pkg::CA_REF_ADDR, 8'h40);
		rd_act();
		chk(tenths, 10'h149, "range 1 base");
		wr_op(ca_vref_pkg::CA_REF_ADDR, 8'h72);
		rd_act();
		chk(tenths, 10'h275, "range 1 top");
		// Frozen write must not land
		clk_en = 1'h0;
		i_mode_cmd_master.issue(1'h1, ca_vref_pkg::CA_REF_ADDR,
			8'h05);
		chk(10'(dq_valid), 10'h000, "frozen write");
		clk_en = 1'h1;
		i_mode_cmd_master.issue(1'h0, 6'h0D, 8'h00);
		chk(10'(dq_valid), 10'h000, "foreign read");
		rd_act();
		repeat (200)
		begin
			wsel = 1'($random(seed));
			osel = 1'($random(seed));
			bmode = 1'($random(seed));
			v = 8'($random(seed));
			wr_op(ca_vref_pkg::CA_REF_ADDR,
				{v[7:6], 6'($unsigned($random(seed)) % 51)});
			rd_act();
		end
		sys_rst_in = 1'h1;
		@(posedge ref_clk_in);
		#2;
		sys_rst_in = 1'h0;
		copy_exp = '{ca_vref_pkg::COPY_RST, ca_vref_pkg::COPY_RST};
		rd_act();
		print_verdict();
	end
endmodule : test_ca_vref_mode_register
